//--- core/feature_bank_pkg.sv
// Function
// [RULE1] misc bit 3 is read/write thermal throttle enable, reset zero
// [RULE2] throttle activates when enabled and the thermal sensor reports overheating
// [RULE3] active throttle in first-generation mode gates clocks at fifty percent duty
// [RULE4] boot firmware must set the throttle enable; hardware never sets it itself
// [RULE5] misc bit 7 is read-only and reports performance monitoring enabled
// [RULE6] misc bit 10 muxes the float error pin onto pending break events
// [RULE7] software using the extended interrupt model must set bit 10
// [RULE8] misc bit 11 is read-only, one when branch trace store unsupported
// [RULE9] misc bit 12 is read-only and reads one: precise sampling unsupported
// [RULE10] misc bit 16 enables frequency scaling; a lock input makes it read-only
// [RULE11] misc bit 23 set stops task priority report messages; reset is a parameter
// [RULE12] last branch top index register is read-only, index in bits 3:0
// [RULE13] debug feature control register is read/write
// [RULE14] with bit 3 clear, mode select has no effect and no throttling runs
// [RULE15] misc feature enable register is read/write for several functions
// [RULE16] reserved misc bits read zero and ignore writes
//
// Purpose: constants and register addresses of the processor feature enable bank
// Assumes: ahb-lite register access, 32-bit words, 64-bit registers split in halves
// Notes: low half at four times the register index, high half at HI_OFS above it
package feature_bank_pkg;
    localparam int HADDR_W = 13;
    localparam logic [10:0] IDX_MISC = 11'h1a0;
    localparam logic [10:0] IDX_TOS = 11'h1c9;
    localparam logic [10:0] IDX_DBG = 11'h1d9;
    localparam logic [HADDR_W-1:0] HI_OFS = 13'h1000;
    localparam logic [HADDR_W-1:0] ADDR_MISC_LO = {IDX_MISC, 2'b00};
    localparam logic [HADDR_W-1:0] ADDR_MISC_HI = ADDR_MISC_LO + HI_OFS;
    localparam logic [HADDR_W-1:0] ADDR_TOS_LO = {IDX_TOS, 2'b00};
    localparam logic [HADDR_W-1:0] ADDR_TOS_HI = ADDR_TOS_LO + HI_OFS;
    localparam logic [HADDR_W-1:0] ADDR_DBG_LO = {IDX_DBG, 2'b00};
    localparam logic [HADDR_W-1:0] ADDR_DBG_HI = ADDR_DBG_LO + HI_OFS;

    localparam int TCC_EN_BIT = 3;
    localparam int PERFMON_BIT = 7;
    localparam int FLOAT_ERROR_PIN_MUX_BIT = 10;
    localparam int BTS_UNAV_BIT = 11;
    localparam int PRECISE_SAMPLE_CAPTURE_UNAV_BIT = 12;
    localparam int FREQ_EN_BIT = 16;
    localparam int TPR_DIS_BIT = 23;
    localparam int TOS_W = 4;

    localparam logic TCC_EN_RST = 1'b0;
    localparam logic FLOAT_ERROR_PIN_MUX_RST = 1'b0;
    localparam logic FREQ_EN_RST = 1'b0;
    localparam logic TPR_DIS_RST = 1'b0;
    localparam logic BTS_UNAV_VAL = 1'b1;
    localparam logic PRECISE_SAMPLE_CAPTURE_UNAV_VAL = 1'b1;
    localparam logic [63:0] DBG_RST = 64'h0;
    localparam logic [TOS_W-1:0] TOS_RST = 4'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage

//--- core/throttle_if.sv
// Purpose: carrier between the register bank and the throttle unit
// Assumes: one clock domain
// Notes: clk_gate high means core clocks run this cycle
`timescale 1ns/1ps
interface throttle_if;
    logic enable;
    logic mode_sel;
    logic active;
    logic clk_gate;
    logic freq_req;
    modport bank (output enable, output mode_sel, input active, input clk_gate, input freq_req);
    modport unit (input enable, input mode_sel, output active, output clk_gate, output freq_req);
endinterface

//--- core/thermal_throttle_unit.sv
// Purpose: thermal throttle circuit driven by the sensor pin
// Assumes: sensor pin is asynchronous to clk_in
// Notes: three-stage synchroniser, a level counts once stages two and three agree
`timescale 1ns/1ps
module thermal_throttle_unit (
    input wire logic clk_in,        // core clock
    input wire logic rst_n_in,      // synchronous reset, active low
    input wire logic sensor_hot_in, // thermal sensor trip, async pin
    throttle_if.unit thr            // bank side controls and status
);
    typedef struct packed {
        logic [2:0] sync;
        logic hot;
        logic active;
        logic clk_gate;
        logic freq_req;
    } unit_state_t;

    localparam unit_state_t UNIT_RST = '{clk_gate: 1'b1, default: '0};

    unit_state_t r;
    unit_state_t nxt;

    always_comb begin
        nxt = r;
        nxt.sync = {r.sync[1:0], sensor_hot_in};
        // stage zero feeds only stage one
        if (r.sync[1] == r.sync[2]) begin
            nxt.hot = r.sync[2];
        end
        nxt.active = thr.enable & r.hot; // [RULE2] [RULE14]
        if (r.active && !thr.mode_sel) begin
            nxt.clk_gate = ~r.clk_gate; // [RULE3]
        end else begin
            nxt.clk_gate = 1'b1;
        end
        // second-generation mode asks for a frequency step instead of gating
        // follows the next active value so the request never outlives active at the bank ports
        nxt.freq_req = nxt.active & thr.mode_sel; // [RULE14]
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            r <= UNIT_RST;
        end else begin
            r <= nxt;
        end
    end

    assign thr.active = r.active;
    assign thr.clk_gate = r.clk_gate;
    assign thr.freq_req = r.freq_req;
endmodule

//--- core/processor_feature_enable_bank.sv
// Purpose: feature enable, last branch index and debug control registers
// Assumes: ahb-lite slave, zero wait states, single word transfers only
// Notes: unmapped reads return zero, unmapped writes are dropped, response always okay
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module processor_feature_enable_bank (
    input wire logic clk_in,                // core clock, 100 MHz
    input wire logic rst_n_in,              // synchronous reset, active low
    input wire logic hsel_in,               // ahb slave select
    input wire logic [12:0] haddr_in,       // ahb byte address
    input wire logic [1:0] htrans_in,       // ahb transfer type
    input wire logic hwrite_in,             // ahb write
    input wire logic [2:0] hsize_in,        // ahb size, word only
    input wire logic [31:0] hwdata_in,      // ahb write data
    input wire logic hready_in,             // ahb bus ready
    output logic [31:0] hrdata_out,         // ahb read data
    output logic hreadyout_out,             // ahb slave ready
    output logic hresp_out,                 // ahb response, always okay
    input wire logic sensor_hot_in,         // thermal sensor trip pin
    input wire logic thermal_mode_select_in, // 0 first-gen, 1 second-gen throttling
    input wire logic perfmon_en_in,         // performance monitoring enabled
    input wire logic freq_lock_in,          // makes frequency scaling enable read-only
    input wire logic fp_error_in,           // legacy float error condition
    input wire logic break_pending_in,      // pending break event
    input wire logic branch_record_in,      // pulse: a branch record was written
    output logic core_clk_gate_out,         // high while core clocks may run
    output logic throttle_active_out,       // thermal throttle circuit active
    output logic freq_step_req_out,         // second-gen frequency step request
    output logic freq_scaling_en_out,       // frequency scaling enabled
    output logic task_priority_report_en_out, // task priority messages allowed
    output logic float_error_pin_out,       // float error pin level
    output logic [63:0] debug_feature_control_out // debug control register contents
);
    typedef struct packed {
        logic tcc_en;
        logic float_error_pin_mux;
        logic freq_en;
        logic tpr_dis;
        logic [63:0] dbg;
        logic [feature_bank_pkg::TOS_W-1:0] tos;
        logic ph_valid;
        logic ph_write;
        logic [12:0] ph_addr;
        logic [31:0] rdata;
        logic float_err;
        logic clk_gate;
        logic thr_active;
        logic freq_req;
        logic tpr_rep_en;
    } bank_state_t;

    localparam bank_state_t BANK_RST = '{
        tcc_en: feature_bank_pkg::TCC_EN_RST,
        float_error_pin_mux: feature_bank_pkg::FLOAT_ERROR_PIN_MUX_RST,
        freq_en: feature_bank_pkg::FREQ_EN_RST,
        tpr_dis: feature_bank_pkg::TPR_DIS_RST,
        dbg: feature_bank_pkg::DBG_RST,
        tos: feature_bank_pkg::TOS_RST,
        clk_gate: 1'b1,
        tpr_rep_en: ~feature_bank_pkg::TPR_DIS_RST,
        default: '0
    };

    bank_state_t r;
    bank_state_t nxt;
    throttle_if thr ();

    thermal_throttle_unit u_throttle (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .sensor_hot_in(sensor_hot_in),
        .thr(thr)
    );

    assign thr.enable = r.tcc_en;
    assign thr.mode_sel = thermal_mode_select_in;

    always_comb begin
        logic [31:0] misc_lo;
        logic addr_phase;
        misc_lo = 32'h0;
        addr_phase = 1'b0;
        nxt = r;

        // write data phase; a write to the read-only index is dropped
        if (r.ph_valid && r.ph_write) begin
            case (r.ph_addr)
                feature_bank_pkg::ADDR_MISC_LO: begin
                    nxt.tcc_en = hwdata_in[feature_bank_pkg::TCC_EN_BIT]; // [RULE1] [RULE15]
                    nxt.float_error_pin_mux = hwdata_in[feature_bank_pkg::FLOAT_ERROR_PIN_MUX_BIT]; // [RULE6]
                    if (!freq_lock_in) begin
                        nxt.freq_en = hwdata_in[feature_bank_pkg::FREQ_EN_BIT]; // [RULE10]
                    end
                    nxt.tpr_dis = hwdata_in[feature_bank_pkg::TPR_DIS_BIT]; // [RULE11]
                end
                feature_bank_pkg::ADDR_DBG_LO: begin
                    nxt.dbg[31:0] = hwdata_in; // [RULE13]
                end
                feature_bank_pkg::ADDR_DBG_HI: begin
                    nxt.dbg[63:32] = hwdata_in; // [RULE13]
                end
                default: begin
                    nxt.dbg = r.dbg;
                end
            endcase
        end

        if (branch_record_in) begin
            nxt.tos = r.tos + 4'h1; // [RULE12]
        end

        // reserved bits stay zero in the read image
        misc_lo[feature_bank_pkg::TCC_EN_BIT] = nxt.tcc_en; // [RULE16]
        misc_lo[feature_bank_pkg::PERFMON_BIT] = perfmon_en_in; // [RULE5]
        misc_lo[feature_bank_pkg::FLOAT_ERROR_PIN_MUX_BIT] = nxt.float_error_pin_mux;
        misc_lo[feature_bank_pkg::BTS_UNAV_BIT] = feature_bank_pkg::BTS_UNAV_VAL; // [RULE8]
        misc_lo[feature_bank_pkg::PRECISE_SAMPLE_CAPTURE_UNAV_BIT] = feature_bank_pkg::PRECISE_SAMPLE_CAPTURE_UNAV_VAL; // [RULE9]
        misc_lo[feature_bank_pkg::FREQ_EN_BIT] = nxt.freq_en;
        misc_lo[feature_bank_pkg::TPR_DIS_BIT] = nxt.tpr_dis;

        // read data built from next-state values so a read right after a write sees it
        if (hready_in) begin
            addr_phase = hsel_in && (htrans_in == feature_bank_pkg::HTRANS_NONSEQ || htrans_in == 2'b11);
            nxt.ph_valid = addr_phase;
            nxt.ph_write = hwrite_in;
            nxt.ph_addr = haddr_in;
            if (addr_phase && !hwrite_in) begin
                case (haddr_in)
                    feature_bank_pkg::ADDR_MISC_LO: nxt.rdata = misc_lo;
                    feature_bank_pkg::ADDR_TOS_LO: nxt.rdata = {28'h0, nxt.tos}; // [RULE12]
                    feature_bank_pkg::ADDR_DBG_LO: nxt.rdata = nxt.dbg[31:0];
                    feature_bank_pkg::ADDR_DBG_HI: nxt.rdata = nxt.dbg[63:32];
                    default: nxt.rdata = 32'h0;
                endcase
            end else begin
                nxt.rdata = 32'h0;
            end
        end

        nxt.float_err = r.float_error_pin_mux ? break_pending_in : fp_error_in; // [RULE6]
        nxt.clk_gate = thr.clk_gate; // [RULE3]
        nxt.thr_active = thr.active; // [RULE2]
        nxt.freq_req = thr.freq_req; // [RULE14]
        // registered inverse keeps the output straight from a flip-flop
        nxt.tpr_rep_en = ~nxt.tpr_dis; // [RULE11]
    end

    // firmware must turn the throttle on; reset leaves it off
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            r <= BANK_RST; // [RULE4]
        end else begin
            r <= nxt;
        end
    end

    assign hrdata_out = r.rdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign core_clk_gate_out = r.clk_gate;
    assign throttle_active_out = r.thr_active;
    assign freq_step_req_out = r.freq_req;
    assign freq_scaling_en_out = r.freq_en;
    assign task_priority_report_en_out = r.tpr_rep_en; // [RULE11]
    assign float_error_pin_out = r.float_err;
    assign debug_feature_control_out = r.dbg;
endmodule

//--- verif/processor_feature_enable_bank_properties.sv
// Purpose: port checks for the feature enable bank
// Assumes: one clock, synchronous active-low reset
// Notes: read tracking follows the ahb data phase
`timescale 1ns/1ps
module feature_bank_props (
    input wire logic clk_in, // clock
    input wire logic rst_n_in, // reset
    input wire logic hsel_in, // select
    input wire logic [12:0] haddr_in, // address
    input wire logic [1:0] htrans_in, // transfer
    input wire logic hwrite_in, // write
    input wire logic hready_in, // bus ready
    input wire logic perfmon_en_in, // perfmon
    input wire logic freq_lock_in, // lock
    input wire logic fp_error_in, // legacy error
    input wire logic break_pending_in, // break
    input wire logic [31:0] hrdata_out, // read data
    input wire logic hreadyout_out, // ready
    input wire logic hresp_out, // response
    input wire logic core_clk_gate_out, // gate
    input wire logic throttle_active_out, // throttle
    input wire logic freq_step_req_out, // step
    input wire logic freq_scaling_en_out, // scaling
    input wire logic float_error_pin_out // error pin
);
    logic rd_misc_r, rd_tos_r, rd_zero_r;
    logic rd_take;
    assign rd_take = rst_n_in && hsel_in && hready_in && htrans_in[1] && !hwrite_in;
    always_ff @(posedge clk_in) begin
        rd_misc_r <= rd_take && haddr_in == feature_bank_pkg::ADDR_MISC_LO;
        rd_tos_r <= rd_take && haddr_in == feature_bank_pkg::ADDR_TOS_LO;
        rd_zero_r <= rd_take && haddr_in == feature_bank_pkg::ADDR_MISC_HI;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    chk_bus_okay: assert property (hreadyout_out && !hresp_out)
        else $error("bus not ready or not okay");
    chk_unavail_flags: assert property (rd_misc_r |-> hrdata_out[12:11] == 2'b11)
        else $error("unavailable flags not set");
    chk_misc_rsvd: assert property (rd_misc_r |-> (hrdata_out & 32'hff7ee377) == 32'h0)
        else $error("reserved bits not zero");
    chk_perfmon_live: assert property (rd_misc_r && $stable(perfmon_en_in) |-> hrdata_out[7] == perfmon_en_in)
        else $error("perfmon bit wrong");
    chk_index_width: assert property (rd_tos_r |-> hrdata_out[31:4] == 28'h0)
        else $error("index above bit 3");
    chk_high_zero: assert property (rd_zero_r |-> hrdata_out == 32'h0)
        else $error("high word not zero");
    chk_float_error_pin_follow: assert property (fp_error_in == break_pending_in |=> float_error_pin_out == $past(fp_error_in))
        else $error("error pin wrong");
    chk_freq_lock: assert property (freq_lock_in && $past(freq_lock_in) |-> $stable(freq_scaling_en_out))
        else $error("locked scaling bit moved");
    chk_gate_idle: assert property (!throttle_active_out && !$past(throttle_active_out) |-> core_clk_gate_out)
        else $error("clocks gated while idle");
    chk_gate_halves: assert property ($fell(core_clk_gate_out) |=> core_clk_gate_out || !throttle_active_out)
        else $error("gate low two cycles");
    chk_step_needs: assert property (freq_step_req_out |-> throttle_active_out)
        else $error("step without throttle");
endmodule
bind processor_feature_enable_bank feature_bank_props u_props (.*);

//--- verif/test_processor_feature_enable_bank.sv
// Purpose: register and throttle scenarios for the feature enable bank
// Assumes: zero wait ahb slave, hsize fixed at word
// Notes: hready loops back from hreadyout as the only slave
`timescale 1ns/1ps
module test_processor_feature_enable_bank;
    logic clk_in = 1'b0, rst_n_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0, hready_in;
    logic [12:0] haddr_in = 13'h0;
    logic [1:0] htrans_in = 2'h0;
    logic [2:0] hsize_in = 3'h2;
    logic [31:0] hwdata_in = 32'h0, hrdata_out, q;
    logic sensor_hot_in = 1'b0, thermal_mode_select_in = 1'b0, perfmon_en_in = 1'b1, freq_lock_in = 1'b0;
    logic fp_error_in = 1'b0, break_pending_in = 1'b0, branch_record_in = 1'b0;
    logic hreadyout_out, hresp_out, core_clk_gate_out, throttle_active_out, freq_step_req_out;
    logic freq_scaling_en_out, task_priority_report_en_out, float_error_pin_out;
    logic [63:0] debug_feature_control_out;
    int fail_count = 0, checks_done = 0, n;
    assign hready_in = hreadyout_out;
    processor_feature_enable_bank u_dut (.*);
    always #5 clk_in = ~clk_in;
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (hready_in !== 1'b1 && k < 20);
        if (k >= 20) begin
            fail_count++;
            finish_test();
        end
    endtask
    task automatic bus(input logic w, input logic [12:0] a, input logic [31:0] d);
        hsel_in <= 1'b1;
        haddr_in <= a;
        hwrite_in <= w;
        htrans_in <= feature_bank_pkg::HTRANS_NONSEQ;
        wait_rdy();
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        wait_rdy();
        q = hrdata_out;
    endtask
    task automatic rd(input logic [12:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic t_regs();
        rd(feature_bank_pkg::ADDR_MISC_LO, 32'h1880);
        chk({core_clk_gate_out, throttle_active_out, freq_scaling_en_out, task_priority_report_en_out}, 4'h9);
        rd(13'h004, 32'h0);
        bus(1'b1, feature_bank_pkg::ADDR_MISC_LO, 32'hffffffff);
        rd(feature_bank_pkg::ADDR_MISC_LO, 32'h00811c88);
        chk({freq_scaling_en_out, task_priority_report_en_out}, 2'b10);
        bus(1'b1, feature_bank_pkg::ADDR_MISC_HI, 32'hffffffff);
        rd(feature_bank_pkg::ADDR_MISC_HI, 32'h0);
        perfmon_en_in <= 1'b0;
        freq_lock_in <= 1'b1;
        bus(1'b1, feature_bank_pkg::ADDR_MISC_LO, 32'h0);
        rd(feature_bank_pkg::ADDR_MISC_LO, 32'h00011800);
        freq_lock_in <= 1'b0;
        bus(1'b1, feature_bank_pkg::ADDR_MISC_LO, 32'h0);
        rd(feature_bank_pkg::ADDR_MISC_LO, 32'h00001800);
    endtask
    task automatic t_float_error_pin();
        fp_error_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk(float_error_pin_out, 1'b1);
        bus(1'b1, feature_bank_pkg::ADDR_MISC_LO, 32'h400);
        repeat (3) @(posedge clk_in);
        chk(float_error_pin_out, 1'b0);
        break_pending_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk(float_error_pin_out, 1'b1);
    endtask
    task automatic t_thermal();
        sensor_hot_in <= 1'b1;
        repeat (12) @(posedge clk_in);
        chk({throttle_active_out, core_clk_gate_out, freq_step_req_out}, 3'b010);
        bus(1'b1, feature_bank_pkg::ADDR_MISC_LO, 32'h8);
        repeat (12) @(posedge clk_in);
        chk(throttle_active_out, 1'b1);
        n = 0;
        repeat (20) begin
            @(posedge clk_in);
            n += core_clk_gate_out;
        end
        chk(n, 10);
        thermal_mode_select_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk({throttle_active_out, freq_step_req_out}, 2'b11);
        sensor_hot_in <= 1'b0;
        repeat (12) @(posedge clk_in);
        chk({throttle_active_out, core_clk_gate_out, freq_step_req_out}, 3'b010);
    endtask
    task automatic t_index_debug();
        branch_record_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        branch_record_in <= 1'b0;
        bus(1'b1, feature_bank_pkg::ADDR_TOS_LO, 32'h0);
        rd(feature_bank_pkg::ADDR_TOS_LO, 32'h5);
        bus(1'b1, feature_bank_pkg::ADDR_DBG_LO, 32'ha5a5a5a5);
        bus(1'b1, feature_bank_pkg::ADDR_DBG_HI, 32'h5a5a5a5a);
        rd(feature_bank_pkg::ADDR_DBG_LO, 32'ha5a5a5a5);
        chk(debug_feature_control_out, 64'h5a5a5a5aa5a5a5a5);
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        t_regs();
        t_float_error_pin();
        t_thermal();
        t_index_debug();
        finish_test();
    end
endmodule
